// *** rtl/mtmr_defines.svh ***
// Offsets, field positions, reset values and counts of the modulo timer.
// Assumes inclusion by the timer module and the test bench only.
`ifndef MTMR_DEFINES_SVH
`define MTMR_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define MTMR_OFF_STATUS_CONTROL 12'h000
`define MTMR_OFF_CLOCK_CONFIG 12'h004
`define MTMR_OFF_COUNT_VALUE 12'h008
`define MTMR_OFF_MODULO_LIMIT 12'h00c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MTMR_SC_OVF_BIT 7
`define MTMR_SC_IRQEN_BIT 6
`define MTMR_SC_CLR_BIT 5
`define MTMR_SC_HALT_BIT 4
`define MTMR_CLK_SRC_HI 5
`define MTMR_CLK_SRC_LO 4
`define MTMR_CLK_PS_HI 3
`define MTMR_CLK_PS_LO 0

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define MTMR_RST_HALT 1'b1
`define MTMR_RST_SRC 2'h0
`define MTMR_RST_PS 4'h0
`define MTMR_RST_COUNT 8'h00
`define MTMR_RST_MODULO 8'h00
`define MTMR_PS_MAX_CODE 4'h8
`define MTMR_PS_WIDTH 8

`endif

// *** rtl/mtmr_pkg.sv ***
// Types shared by the modulo timer.
// Assumes the defines header sits beside it.
package mtmr_pkg;
   // Clock source select codes
   typedef enum logic [1:0] {
      MTMR_SRC_BUS = 2'h0,
      MTMR_SRC_FIXED = 2'h1,
      MTMR_SRC_PIN_FALL = 2'h2,
      MTMR_SRC_PIN_RISE = 2'h3
   } mtmr_src_t;

   // Power state, one-hot
   typedef enum logic [2:0] {
      MTMR_PWR_RUN = 3'b001,
      MTMR_PWR_STOP = 3'b010,
      MTMR_PWR_DEBUG = 3'b100
   } mtmr_pwr_t;
endpackage

// *** rtl/mtmr_modulo_timer.sv ***
// Modulo timer: 8-bit up-counter, prescaler, four registers on APB.
// Assumes a 10 MHz ref_clk as bus clock; the pin and the fixed clock
// come from other domains and are synchronised here.
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "mtmr_defines.svh"

// Notes on behaviour
// - Eight-bit up-counter, free-running or wrapping at a programmable modulo value.
// - Source codes 11 and 10 count from the external count pin.
// - Pin may feed this timer and the other timer simultaneously.
// - Sources: bus clock, fixed clock rising, pin rising, pin falling.
// - Prescaler divides by 1, 2, 4, 8, 16, 32, 64, 128 or 256.
// - Counting continues during wait mode if enabled beforehand.
// - Stop modes halt everything; never a wake-up source.
// - Leaving deep stop, or light stop by reset, gives full reset state.
// - Leaving light stop by interrupt keeps state; counting resumes.
// - Debug mode suspends counting; resume from held value.
// - Pin is synchronised to the bus clock before edge detection.
// - Overflow flag, bit 7, sets when count wraps past modulo.
// - Flag clears by reading it set, then writing zero.
// - Clear bit write or modulo write also clears the flag.
// - Interrupt asserted while enable bit 6 and flag both set.
// - Write-only bit 5 clears counter and flag; reads zero.
// - Halt bit 4 holds the counter; resumes when cleared.
// - Halt bit is set after reset.
// - Status bits 3 to 0 read zero.
// - Four 8-bit registers: status, clock config, count, modulo.
// - Source 00 bus, 01 fixed, 10 pin falling, 11 pin rising.
// - Prescale code n divides by two to the n; above 8 is 256.
// - Count equal to nonzero modulo wraps to zero, sets flag.
// - Modulo zero means free-running; modulo resets to zero.
module mtmr_modulo_timer
   import mtmr_pkg::*;
#(
   parameter int PS_WIDTH = `MTMR_PS_WIDTH
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_count_pin,
   input wire logic fixed_freq_clock,
   input wire logic stop_mode,
   input wire logic deep_stop_wake,
   input wire logic debug_active,
   output logic timer_irq,
   output logic [7:0] count_out
);

   // ----------------------------------------
   // Registers and state
   // ----------------------------------------
   logic overflowFlag;
   logic irqEnable;
   logic counterHalt;
   mtmr_src_t clockSource;
   logic [3:0] prescaleSelect;
   logic [7:0] countValue;
   logic [7:0] moduloValue;
   logic flagSeenSet;
   logic [PS_WIDTH-1:0] prescaler;
   mtmr_pwr_t pwrState;
   logic pinSync1;
   logic pinSync2;
   logic pinLast;
   logic fixSync1;
   logic fixSync2;
   logic fixLast;
   logic deepReset;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   logic access;
   logic wrAccess;
   logic rdAccess;
   logic offScs;
   logic offClk;
   logic offCnt;
   logic offMod;
   logic mapped;
   assign access = psel && penable;
   assign wrAccess = access && pwrite;
   assign rdAccess = access && !pwrite;
   assign offScs = paddr == `MTMR_OFF_STATUS_CONTROL;
   assign offClk = paddr == `MTMR_OFF_CLOCK_CONFIG;
   assign offCnt = paddr == `MTMR_OFF_COUNT_VALUE;
   assign offMod = paddr == `MTMR_OFF_MODULO_LIMIT;
   assign mapped = offScs || offClk || offCnt || offMod;

   logic scWrite;
   logic clearWrite;
   logic modWrite;
   logic softClear;
   assign scWrite = wrAccess && offScs;
   assign clearWrite = scWrite && pwdata[`MTMR_SC_CLR_BIT];
   assign modWrite = wrAccess && offMod;
   assign softClear = clearWrite || modWrite;

   // ----------------------------------------
   // Power state
   // ----------------------------------------
   // Deep stop wake is a full reset of the block; light stop keeps state
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pwrState <= MTMR_PWR_RUN;
      end else begin
         case (pwrState)
            MTMR_PWR_RUN: begin
               if (stop_mode) begin
                  pwrState <= MTMR_PWR_STOP;
               end else if (debug_active) begin
                  pwrState <= MTMR_PWR_DEBUG;
               end
            end
            MTMR_PWR_STOP: begin
               if (!stop_mode) begin
                  pwrState <= MTMR_PWR_RUN;
               end
            end
            MTMR_PWR_DEBUG: begin
               if (stop_mode) begin
                  pwrState <= MTMR_PWR_STOP;
               end else if (!debug_active) begin
                  pwrState <= MTMR_PWR_RUN;
               end
            end
            default: begin
               pwrState <= MTMR_PWR_RUN;
            end
         endcase
      end
   end

   // Deep stop exit marker, acted on as a synchronous block reset
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         deepReset <= 1'b0;
      end else begin
         deepReset <= stop_mode && deep_stop_wake;
      end
   end

   // ----------------------------------------
   // Source synchronisers and edges
   // ----------------------------------------
   // Pin edges only reliable up to a quarter of the bus rate
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pinSync1 <= 1'b0;
         pinSync2 <= 1'b0;
         pinLast <= 1'b0;
         fixSync1 <= 1'b0;
         fixSync2 <= 1'b0;
         fixLast <= 1'b0;
      end else begin
         pinSync1 <= ext_count_pin;
         pinSync2 <= pinSync1;
         pinLast <= pinSync2;
         fixSync1 <= fixed_freq_clock;
         fixSync2 <= fixSync1;
         fixLast <= fixSync2;
      end
   end

   // Pin is only sampled, so other timers may share it
   logic pinRise;
   logic pinFall;
   logic fixRise;
   logic srcTick;
   assign pinRise = pinSync2 && !pinLast;
   assign pinFall = !pinSync2 && pinLast;
   assign fixRise = fixSync2 && !fixLast;

   // ----------------------------------------
   // Clock source select
   // ----------------------------------------
   // Unused codes cannot occur, but fall back to the bus clock
   always_comb begin
      case (clockSource)
         MTMR_SRC_BUS: srcTick = 1'b1;
         MTMR_SRC_FIXED: srcTick = fixRise;
         MTMR_SRC_PIN_FALL: srcTick = pinFall;
         MTMR_SRC_PIN_RISE: srcTick = pinRise;
         default: srcTick = 1'b1;
      endcase
   end

   // ----------------------------------------
   // Prescaler
   // ----------------------------------------
   logic running;
   logic [PS_WIDTH-1:0] psMask;
   logic [3:0] psCode;
   logic countTick;
   // Wait mode needs no input: the timer simply keeps running
   assign running = !counterHalt && (pwrState == MTMR_PWR_RUN);
   assign psCode = (prescaleSelect > `MTMR_PS_MAX_CODE) ? `MTMR_PS_MAX_CODE
      : prescaleSelect;

   genvar gi;
   generate
      for (gi = 0; gi < PS_WIDTH; gi++) begin : g_mask
         assign psMask[gi] = (gi < psCode);
      end
   endgenerate

   // Tick when all selected low prescaler bits are ones
   assign countTick = running && srcTick && ((prescaler & psMask) == psMask);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         prescaler <= '0;
      end else if (deepReset || softClear) begin
         prescaler <= '0;
      end else if (running && srcTick) begin
         prescaler <= prescaler + 1'b1;
      end
   end

   // ----------------------------------------
   // Counter and overflow
   // ----------------------------------------
   logic wrapNow;
   assign wrapNow = countTick && (moduloValue != 8'h00) && (countValue == moduloValue);
   logic rollNow;
   assign rollNow = countTick && (moduloValue == 8'h00) && (countValue == 8'hff);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         countValue <= `MTMR_RST_COUNT;
      end else if (deepReset || softClear) begin
         countValue <= `MTMR_RST_COUNT;
      end else if (wrapNow) begin
         countValue <= 8'h00;
      end else if (countTick) begin
         countValue <= countValue + 8'h01;
      end
   end

   // A clear bit or modulo write beats a set in the same cycle; a set beats the flag clear write
   logic flagClearWrite;
   assign flagClearWrite = scWrite && flagSeenSet && !pwdata[`MTMR_SC_OVF_BIT];
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         overflowFlag <= 1'b0;
      end else if (deepReset) begin
         overflowFlag <= 1'b0;
      end else if ((wrapNow || rollNow) && !softClear) begin
         overflowFlag <= 1'b1;
      end else if (softClear || flagClearWrite) begin
         overflowFlag <= 1'b0;
      end
   end


   // ----------------------------------------
   // Flag clear handshake
   // ----------------------------------------
   // Arms only on the flag value actually returned: a flag that set
   // between setup and access was never seen, so it must not be cleared
   logic statusSawFlag;
   assign statusSawFlag = rdAccess && offScs && prdata[`MTMR_SC_OVF_BIT];
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         flagSeenSet <= 1'b0;
      end else if (deepReset || !overflowFlag) begin
         flagSeenSet <= 1'b0;
      end else if (statusSawFlag) begin
         flagSeenSet <= 1'b1;
      end else if (scWrite) begin
         flagSeenSet <= 1'b0;
      end
   end

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irqEnable <= 1'b0;
         counterHalt <= `MTMR_RST_HALT;
      end else if (deepReset) begin
         irqEnable <= 1'b0;
         counterHalt <= `MTMR_RST_HALT;
      end else if (scWrite) begin
         irqEnable <= pwdata[`MTMR_SC_IRQEN_BIT];
         counterHalt <= pwdata[`MTMR_SC_HALT_BIT];
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         clockSource <= mtmr_src_t'(`MTMR_RST_SRC);
         prescaleSelect <= `MTMR_RST_PS;
      end else if (deepReset) begin
         clockSource <= mtmr_src_t'(`MTMR_RST_SRC);
         prescaleSelect <= `MTMR_RST_PS;
      end else if (wrAccess && offClk) begin
         clockSource <= mtmr_src_t'(pwdata[`MTMR_CLK_SRC_HI:`MTMR_CLK_SRC_LO]);
         prescaleSelect <= pwdata[`MTMR_CLK_PS_HI:`MTMR_CLK_PS_LO];
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         moduloValue <= `MTMR_RST_MODULO;
      end else if (deepReset) begin
         moduloValue <= `MTMR_RST_MODULO;
      end else if (modWrite) begin
         moduloValue <= pwdata[7:0];
      end
   end

   // ----------------------------------------
   // Read data and bus answer
   // ----------------------------------------
   logic [7:0] next_rdByte;
   always_comb begin
      next_rdByte = 8'h00;
      if (offScs) begin
         // Clear bit and low nibble always read zero
         next_rdByte = {overflowFlag, irqEnable, 1'b0, counterHalt, 4'h0};
      end else if (offClk) begin
         next_rdByte = {2'h0, clockSource, prescaleSelect};
      end else if (offCnt) begin
         next_rdByte = countValue;
      end else if (offMod) begin
         next_rdByte = moduloValue;
      end
   end

   // No wait state: answer in the first access cycle after setup
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         if (psel && !penable && !pwrite) begin
            prdata <= {24'h00_0000, next_rdByte};
         end
      end
   end

   // Writes take effect only at the completing edge
   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         timer_irq <= 1'b0;
         count_out <= 8'h00;
      end else begin
         timer_irq <= irqEnable && overflowFlag;
         count_out <= countValue;
      end
   end

endmodule // mtmr_modulo_timer

// *** test/mtmr_timer_sva.sv ***
// Port checker for the modulo timer.
// Assumes a bind onto mtmr_modulo_timer; one clock, rst async high.
`timescale 1ns/10ps
module mtmr_timer_sva #(
   parameter int PS_WIDTH = 8
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic stop_mode,
   input wire logic deep_stop_wake,
   input wire logic debug_active,
   input wire logic timer_irq,
   input wire logic [7:0] count_out
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic rdAcc;
   assign rdAcc = psel && penable && pready && !pwrite;
   // ----------------------------------------
   // Bus answer
   // ----------------------------------------
   chk_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   chk_ready_one_cycle: assert property (pready |=> !pready)
      else $error("pready held too long");
   chk_unmapped_err: assert property (rdAcc && paddr > 12'h00c |-> pslverr)
      else $error("unmapped read without pslverr");
   chk_upper_zero: assert property (rdAcc |-> prdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   chk_status_zeros: assert property (rdAcc && paddr == 12'h000
      |-> prdata[5] == 1'b0 && prdata[3:0] == 4'h0)
      else $error("status reserved bits not zero");
   // ----------------------------------------
   // Counter and interrupt
   // ----------------------------------------
   chk_irq_from_flag: assert property (rdAcc && paddr == 12'h000 && prdata[7:6] == 2'b11
      |-> ##[0:2] timer_irq)
      else $error("irq low with flag and enable set");
   chk_count_step: assert property ($changed(count_out)
      |-> count_out == $past(count_out) + 8'h01 || count_out == 8'h00)
      else $error("count moved by other than one");
   // Writes during stop could legally clear, so bus idle is required
   chk_stop_freeze: assert property ((stop_mode && !deep_stop_wake && !psel) [*4]
      |-> $stable(count_out))
      else $error("count moved in stop");
   chk_debug_freeze: assert property ((debug_active && !psel) [*4]
      |-> $stable(count_out))
      else $error("count moved in debug");
endmodule // mtmr_timer_sva

bind mtmr_modulo_timer mtmr_timer_sva #(.PS_WIDTH(PS_WIDTH)) i_mtmr_timer_sva (
   .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .stop_mode(stop_mode), .deep_stop_wake(deep_stop_wake),
   .debug_active(debug_active), .timer_irq(timer_irq), .count_out(count_out));

// *** test/mtmr_pin_model.sv ***
// Far side: external count pin and a free-running fixed clock.
// Assumes pulse() is called from the bench's ref_clk domain.
`timescale 1ns/10ps
module mtmr_pin_model (
   input wire logic ref_clk,
   output logic pin,
   output logic fixedClk
);
   initial begin
      pin = 1'b0;
      fixedClk = 1'b0;
   end
   // Fixed clock runs free at eight ref_clk periods, toggling on ref_clk falling edges
   always #400 fixedClk = ~fixedClk;
   // Six bus cycles per period keeps the pin well under a quarter rate
   task automatic pulse(input int n);
      repeat (n) begin
         repeat (3) @(posedge ref_clk);
         pin <= 1'b1;
         repeat (3) @(posedge ref_clk);
         pin <= 1'b0;
      end
   endtask
endmodule // mtmr_pin_model

// *** test/mtmr_modulo_timer_test.sv ***
// Self-checking bench for the modulo timer over APB.
// Assumes the pin model drives the count pin and fixed clock.
`timescale 1ns/10ps
`include "mtmr_defines.svh"
`define CHK(n, e, g) begin samples_checked++; if ((e) !== (g)) begin bad_count++; \
   $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module mtmr_modulo_timer_test;
   import mtmr_pkg::*;
   localparam logic [11:0] SC = `MTMR_OFF_STATUS_CONTROL;
   localparam logic [11:0] CK = `MTMR_OFF_CLOCK_CONFIG;
   localparam logic [11:0] CN = `MTMR_OFF_COUNT_VALUE;
   localparam logic [11:0] MD = `MTMR_OFF_MODULO_LIMIT;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, pin, fixedClk, timer_irq;
   logic stop_mode = 1'b0, deep_stop_wake = 1'b0, debug_active = 1'b0;
   logic [7:0] count_out;
   logic [32:0] expQ[$];
   logic [32:0] expNote;
   int bad_count = 0;
   int samples_checked = 0;
   always #50 ref_clk = ~ref_clk;
   mtmr_modulo_timer #(.PS_WIDTH(8)) i_mtmr_modulo_timer (.ref_clk(ref_clk), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_count_pin(pin),
      .fixed_freq_clock(fixedClk), .stop_mode(stop_mode), .deep_stop_wake(deep_stop_wake),
      .debug_active(debug_active), .timer_irq(timer_irq), .count_out(count_out));
   mtmr_pin_model i_mtmr_pin_model (.ref_clk(ref_clk), .pin(pin), .fixedClk(fixedClk));
   // ----------------------------------------
   // Read monitor
   // ----------------------------------------
   always @(posedge ref_clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         expNote = expQ.pop_front();
         `CHK("prdata", expNote[31:0], prdata)
         `CHK("pslverr", expNote[32], pslverr)
      end
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // Waits as long as the slave needs; only the watchdog ends a hang
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      xfer(1'b1, a, {24'h0, d});
   endtask
   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      expQ.push_back(e);
      xfer(1'b0, a, 32'h0);
   endtask
   task automatic pp(input int n);
      i_mtmr_pin_model.pulse(n);
      repeat (6) @(posedge ref_clk);
   endtask
   task automatic tally_and_finish;
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      $display("[FAIL] watchdog expected done seen timeout");
      tally_and_finish;
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      int seed;
      logic [7:0] cfg;
      seed = 39640;
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      rd(SC, 33'h10);
      rd(CK, 33'h00);
      rd(CN, 33'h00);
      rd(MD, 33'h00);
      rd(12'h010, 33'h1_0000_0000);
      $display("test reset done");
      for (int s = 0; s < 4; s++) begin
         cfg = {2'b00, 2'(s), 4'($random(seed))};
         wr(CK, cfg);
         rd(CK, {25'h0, cfg});
      end
      $display("test config done");
      wr(CK, 8'h30);
      wr(MD, 8'h05);
      wr(SC, 8'h00);
      pp(4);
      rd(CN, 33'h04);
      pp(2);
      rd(CN, 33'h00);
      rd(SC, 33'h80);
      wr(SC, 8'h00);
      rd(SC, 33'h00);
      $display("test modulo done");
      wr(CK, 8'h20);
      pp(3);
      rd(CN, 33'h03);
      wr(SC, 8'h10);
      pp(2);
      rd(CN, 33'h03);
      wr(SC, 8'h00);
      stop_mode <= 1'b1;
      pp(2);
      stop_mode <= 1'b0;
      rd(CN, 33'h03);
      debug_active <= 1'b1;
      pp(2);
      debug_active <= 1'b0;
      rd(CN, 33'h03);
      pp(1);
      rd(CN, 33'h04);
      $display("test hold done");
      wr(CK, 8'h21);
      wr(MD, 8'h00);
      pp(6);
      rd(CN, 33'h03);
      wr(SC, 8'h20);
      rd(CN, 33'h00);
      rd(SC, 33'h00);
      $display("test prescale done");
      wr(MD, 8'h02);
      wr(SC, 8'h40);
      pp(6);
      rd(SC, 33'hc0);
      `CHK("timer_irq", 1'b1, timer_irq)
      wr(MD, 8'h02);
      rd(SC, 33'h40);
      repeat (2) @(posedge ref_clk);
      `CHK("timer_irq", 1'b0, timer_irq)
      $display("test irq done");
      // Bus clock divided by 8, then fixed clock of 8 bus cycles: 80 running edges each
      for (int s = 0; s < 2; s++) begin
         wr(SC, 8'h10);
         wr(CK, s ? 8'h10 : 8'h03);
         wr(MD, 8'h00);
         wr(SC, 8'h00);
         repeat (77) @(posedge ref_clk);
         wr(SC, 8'h10);
         rd(CN, 33'h0a);
      end
      $display("test source done");
      stop_mode <= 1'b1;
      deep_stop_wake <= 1'b1;
      repeat (2) @(posedge ref_clk);
      stop_mode <= 1'b0;
      deep_stop_wake <= 1'b0;
      rd(SC, 33'h10);
      rd(MD, 33'h00);
      $display("test deep stop done");
      repeat (2) @(posedge ref_clk);
      tally_and_finish;
   end
endmodule // mtmr_modulo_timer_test
